// *** hw/phy_event_cfg.svh ***
// constants for the phy event status and speed downshift block
// assumes a 200 MHz core clock and a word-addressed register bus
//
// Behaviour
// (RULE_01) Status bit 15 latches on a master/slave fault, a parallel detect fault, no common ability, or link not up after negotiation.
// (RULE_02) Status bit 14 latches when the operating speed changes.
// (RULE_03) Status bit 13 latches when the duplex setting changes.
// (RULE_04) Status bit 12 latches when a negotiation page arrives from the partner.
// (RULE_05) Status bit 11 latches when the link goes down.
// (RULE_06) Status bit 6 latches when the crossover setting changes.
// (RULE_07) Status bit 5 latches when an automatic speed downgrade happens.
// (RULE_08) Status bit 1 latches on a receive polarity change and bit 0 on jabber.
// (RULE_09) Bits 15 to 11 of the downshift control register always read zero.
// (RULE_10) The downshift enable bit 5 resets to one.
// (RULE_11) With downshift enabled, repeated training failures drop the advertised speed from 100 to 10.
// (RULE_12) The attempt limit at bits 4 to 2 resets to 3 and means limit plus two attempts.
// (RULE_13) The bypass bit 1 skips the stability timer and resets to zero.
// (RULE_14) A latched event drives the interrupt only when its enable bit is set.
// (RULE_15) Latched bits stay set until the status register is read, then clear unless the cause persists; a REG_CLEAR write also drops the written bits.
// (RULE_16) Hardware reset clears the status bits; software reset keeps them.
// (RULE_17) Status bit 10 latches when the link comes up.
`ifndef PHY_EVENT_CFG_SVH
`define PHY_EVENT_CFG_SVH

`define REG_IRQ_EN 5'h12
`define REG_STATUS 5'h13
`define REG_DS_CTRL 5'h14
`define REG_CLEAR 5'h18
`define REG_DS_STATE 5'h19

`define B_AN_ERR 15
`define B_SPEED 14
`define B_DUPLEX 13
`define B_PAGE 12
`define B_LINK_DOWN 11
`define B_LINK_UP 10
`define B_MDIX 6
`define B_DOWN 5
`define B_POL 1
`define B_JAB 0
`define STATUS_MASK 16'hFC63

`define DS_EN 5
`define DS_LIM_HI 4
`define DS_LIM_LO 2
`define DS_BYP 1
`define DS_CTRL_RST 16'h002C
`define DS_CTRL_WMASK 16'h06FF
`define DS_CTRL_SOFT_CLR 16'h0001
`define DS_EXTRA_TRIES 4'h2
`define IRQ_EN_RST 16'h0000
`define IRQ_EN_SOFT_CLR 16'h0100

`define CLK_MHZ 200
`define DS_STAB_US 1000
`define DS_STAB_CYC (`DS_STAB_US * `CLK_MHZ)
`define LINK_WAIT_US 2000
`define LINK_WAIT_CYC (`LINK_WAIT_US * `CLK_MHZ)

`endif

// *** hw/phy_event_pkg.sv ***
// types shared by the phy event status block
// assumes the indication inputs come from logic on the core clock
package phy_event_pkg;

    typedef struct packed {
        logic ms_fault;
        logic pd_fault;
        logic no_highest_common_ability;
        logic an_done;
        logic link_up;
        logic speed_100;
        logic full_duplex;
        logic page_rx;
        logic mdix;
        logic pol_rev;
        logic jabber;
        logic train_fail;
    } phy_ind_s;

    typedef enum logic [1:0] {
        DS_IDLE,
        DS_WAIT,
        DS_DOWN
    } ds_state_e;

endpackage

// *** hw/phy_event_status.sv ***
// event status latches, interrupt and speed downshift control
// assumes indications are synchronous to core_clk_in, word-addressed avalon-mm
//
// The Avalon-MM slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "phy_event_cfg.svh"

module phy_event_status import phy_event_pkg::*; #(
    parameter int STAB_CYC = `DS_STAB_CYC,
    parameter int LINK_WAIT_CYC = `LINK_WAIT_CYC
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic soft_rst_in,
    input wire phy_ind_s phy_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic irq_out,
    output logic adv_100_out
);

    phy_ind_s prev_q;
    logic [15:0] status_q;
    logic [15:0] status_d;
    logic [15:0] irq_en_q;
    logic [15:0] irq_en_d;
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic wait_q;
    logic [31:0] rdata_q;
    logic irq_q;
    logic adv_q;
    logic [19:0] lw_cnt_q;
    logic [19:0] lw_cnt_d;
    ds_state_e state_q;
    ds_state_e state_d;
    logic [3:0] tries_q;
    logic [3:0] tries_d;
    logic [19:0] timer_q;
    logic [19:0] timer_d;

    // bus decode
    wire req = avs_read_in | avs_write_in;
    wire acc = req & ~wait_q;
    wire [15:0] be_mask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    wire [15:0] wdata = avs_writedata_in[15:0];
    wire rd_stat = acc & avs_read_in & (avs_address_in == `REG_STATUS);
    wire wr_en = acc & avs_write_in & (avs_address_in == `REG_IRQ_EN);
    wire wr_ctrl = acc & avs_write_in & (avs_address_in == `REG_DS_CTRL);
    wire wr_clr = acc & avs_write_in & (avs_address_in == `REG_CLEAR);
    wire [15:0] ds_view = {10'h000, state_q == DS_DOWN, state_q == DS_WAIT, tries_q};
    wire [15:0] rmux =
        (avs_address_in == `REG_IRQ_EN) ? irq_en_q :
        // next status value, so an event just before the read is reported, not lost
        (avs_address_in == `REG_STATUS) ? status_d :
        (avs_address_in == `REG_DS_CTRL) ? ctrl_q :
        (avs_address_in == `REG_DS_STATE) ? ds_view : 16'h0000;

    // downshift controls
    wire ds_en = ctrl_q[`DS_EN];
    wire ds_byp = ctrl_q[`DS_BYP];
    wire [3:0] tries_need = {1'b0, ctrl_q[`DS_LIM_HI:`DS_LIM_LO]} + `DS_EXTRA_TRIES; // RULE_12
    wire tries_full = (tries_q + 4'h1) >= tries_need;
    wire stab_done = ds_byp | (timer_q == 20'(STAB_CYC - 1)); // RULE_13
    wire ds_go = (state_q == DS_WAIT) & ds_en & ~phy_in.link_up & stab_done & ~soft_rst_in;

    // link not up in time after negotiation, fires once per wait
    // counter parks one past the firing count so the event cannot repeat
    wire lw_wait = phy_in.an_done & ~phy_in.link_up;
    wire lw_fire = lw_wait & (lw_cnt_q == 20'(LINK_WAIT_CYC - 1));
    wire lw_done = (lw_cnt_q == 20'(LINK_WAIT_CYC));
    assign lw_cnt_d = ~lw_wait ? 20'h00000 : lw_done ? lw_cnt_q : lw_cnt_q + 20'h00001;

    // event sources
    wire [15:0] ev;
    assign ev[`B_AN_ERR] = phy_in.ms_fault | phy_in.pd_fault | phy_in.no_highest_common_ability | lw_fire; // RULE_01
    assign ev[`B_SPEED] = phy_in.speed_100 ^ prev_q.speed_100; // RULE_02
    assign ev[`B_DUPLEX] = phy_in.full_duplex ^ prev_q.full_duplex; // RULE_03
    assign ev[`B_PAGE] = phy_in.page_rx; // RULE_04
    assign ev[`B_LINK_DOWN] = prev_q.link_up & ~phy_in.link_up; // RULE_05
    assign ev[`B_LINK_UP] = phy_in.link_up & ~prev_q.link_up; // RULE_17
    assign ev[9:7] = 3'h0;
    assign ev[`B_MDIX] = phy_in.mdix ^ prev_q.mdix; // RULE_06
    assign ev[`B_DOWN] = ds_go; // RULE_07
    assign ev[4:2] = 3'h0;
    assign ev[`B_POL] = phy_in.pol_rev ^ prev_q.pol_rev; // RULE_08
    assign ev[`B_JAB] = phy_in.jabber; // RULE_08

    // a read or a clear write drops bits, but a same-cycle event wins
    wire [15:0] clr = rd_stat ? 16'hFFFF : (wr_clr ? (wdata & be_mask) : 16'h0000);
    assign status_d = ((status_q & ~clr) | ev) & `STATUS_MASK; // RULE_15

    assign irq_en_d = soft_rst_in ? (irq_en_q & ~`IRQ_EN_SOFT_CLR) :
        wr_en ? ((irq_en_q & ~be_mask) | (wdata & be_mask)) : irq_en_q;
    // upper bits never stored, so they read zero
    assign ctrl_d = soft_rst_in ? (ctrl_q & ~`DS_CTRL_SOFT_CLR) :
        wr_ctrl ? ((ctrl_q & ~(be_mask & `DS_CTRL_WMASK)) | (wdata & be_mask & `DS_CTRL_WMASK)) : ctrl_q; // RULE_09

    always_comb begin
        state_d = state_q;
        tries_d = tries_q;
        timer_d = 20'h00000;
        if (soft_rst_in || !ds_en) begin
            state_d = DS_IDLE;
            tries_d = 4'h0;
        end else begin
            case (state_q)
                DS_IDLE: begin
                    if (phy_in.link_up) begin
                        tries_d = 4'h0;
                    end else if (phy_in.train_fail && tries_full) begin
                        state_d = DS_WAIT;
                        tries_d = 4'h0;
                    end else if (phy_in.train_fail) begin
                        tries_d = tries_q + 4'h1;
                    end
                end
                DS_WAIT: begin
                    // stable link while waiting means the cable is usable at 100
                    if (phy_in.link_up) begin
                        state_d = DS_IDLE;
                    end else if (ds_go) begin
                        state_d = DS_DOWN; // RULE_11
                    end else begin
                        timer_d = timer_q + 20'h00001;
                    end
                end
                DS_DOWN: begin
                    state_d = DS_DOWN;
                end
                default: begin
                    state_d = DS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            status_q <= 16'h0000; // RULE_16
            irq_en_q <= `IRQ_EN_RST;
            ctrl_q <= `DS_CTRL_RST; // RULE_10
            // follow the inputs so no false change shows right after reset
            prev_q <= phy_in;
            lw_cnt_q <= 20'h00000;
        end else begin
            status_q <= status_d;
            irq_en_q <= irq_en_d;
            ctrl_q <= ctrl_d;
            prev_q <= phy_in;
            lw_cnt_q <= lw_cnt_d;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_q <= DS_IDLE;
            tries_q <= 4'h0;
            timer_q <= 20'h00000;
            adv_q <= 1'b1;
            irq_q <= 1'b0;
        end else begin
            state_q <= state_d;
            tries_q <= tries_d;
            timer_q <= timer_d;
            adv_q <= (state_d != DS_DOWN);
            irq_q <= |(status_d & irq_en_d); // RULE_14
        end
    end

    // one wait cycle per access; read data is staged before release
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= ~(req & wait_q);
            if (req && wait_q) begin
                rdata_q <= {16'h0000, rmux};
            end
        end
    end

    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign irq_out = irq_q;
    assign adv_100_out = adv_q;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    property p_an_err;
        (phy_in.ms_fault || phy_in.pd_fault || phy_in.no_highest_common_ability) |=> status_q[`B_AN_ERR];
    endproperty
    a_an_err: assert property (p_an_err) else $error("negotiation error not latched"); // RULE_01

    property p_speed;
        (phy_in.speed_100 != $past(phy_in.speed_100)) |=> status_q[`B_SPEED];
    endproperty
    a_speed: assert property (p_speed) else $error("speed change not latched"); // RULE_02

    property p_duplex;
        (phy_in.full_duplex != prev_q.full_duplex) |=> status_q[`B_DUPLEX];
    endproperty
    a_duplex: assert property (p_duplex) else $error("duplex change not latched"); // RULE_03

    property p_page;
        phy_in.page_rx |=> status_q[`B_PAGE];
    endproperty
    a_page: assert property (p_page) else $error("page receipt not latched"); // RULE_04

    property p_link_down;
        $fell(phy_in.link_up) |=> status_q[`B_LINK_DOWN];
    endproperty
    a_link_down: assert property (p_link_down) else $error("link down not latched"); // RULE_05

    property p_mdix;
        $changed(phy_in.mdix) |=> status_q[`B_MDIX];
    endproperty
    a_mdix: assert property (p_mdix) else $error("crossover change not latched"); // RULE_06

    property p_down;
        ds_go |=> status_q[`B_DOWN] && !adv_100_out;
    endproperty
    a_down: assert property (p_down) else $error("downgrade not latched"); // RULE_07

    property p_pol_jab;
        ($changed(phy_in.pol_rev) |=> status_q[`B_POL]) and (phy_in.jabber |=> status_q[`B_JAB]);
    endproperty
    a_pol_jab: assert property (p_pol_jab) else $error("polarity or jabber not latched"); // RULE_08

    property p_ctrl_rsv;
        (acc && avs_read_in && avs_address_in == `REG_DS_CTRL) |-> avs_readdata_out[15:11] == 5'h00;
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved control bits not zero"); // RULE_09

    property p_ctrl_rst;
        @(posedge core_clk_in) disable iff (1'b0) rst_in |=> (ctrl_q[`DS_EN] && ctrl_q[4:2] == 3'b011 && !ctrl_q[`DS_BYP]);
    endproperty
    a_ctrl_rst: assert property (p_ctrl_rst) else $error("control reset value wrong"); // RULE_10

    property p_adv_hold;
        (state_q != DS_DOWN) |-> adv_100_out;
    endproperty
    a_adv_hold: assert property (p_adv_hold) else $error("speed lowered without downgrade"); // RULE_11

    property p_tries;
        (state_q == DS_IDLE && ds_en && !soft_rst_in && phy_in.train_fail && !phy_in.link_up
            && tries_q == tries_need - 4'h1) |=> state_q == DS_WAIT;
    endproperty
    a_tries: assert property (p_tries) else $error("attempt limit not honoured"); // RULE_12

    property p_bypass;
        (state_q == DS_WAIT && ds_byp && ds_en && !phy_in.link_up && !soft_rst_in) |=> state_q == DS_DOWN;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass did not skip timer"); // RULE_13

    property p_irq;
        irq_out == |(status_q & irq_en_q);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt does not follow enabled status"); // RULE_14

    property p_rd_clear;
        rd_stat |=> status_q == ($past(ev) & `STATUS_MASK);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read did not clear status"); // RULE_15

    property p_soft_keep;
        (soft_rst_in && !rd_stat && !wr_clr) |=> status_q == (($past(status_q) | $past(ev)) & `STATUS_MASK);
    endproperty
    a_soft_keep: assert property (p_soft_keep) else $error("soft reset disturbed status"); // RULE_16

    property p_link_up;
        $rose(phy_in.link_up) |=> status_q[`B_LINK_UP];
    endproperty
    a_link_up: assert property (p_link_up) else $error("link up not latched"); // RULE_17

endmodule // phy_event_status

// *** dv/mgmt_host_model.sv ***
// management host model: avalon-mm master on the block's register bus
// assumes waitrequest low marks the one edge where an access completes
`timescale 1ns/1ps
module mgmt_host_model (
    input wire logic core_clk_in,
    input wire logic wait_in,
    output logic [4:0] addr_out,
    output logic rd_out,
    output logic wr_out,
    output logic [31:0] wdata_out,
    output logic [3:0] be_out
);
    initial begin
        addr_out = 5'h00;
        rd_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 32'h0;
        be_out = 4'h0;
    end

    // no fixed latency assumed: waits for waitrequest low however long it takes
    task automatic access(input logic [4:0] a, input logic w, input logic [15:0] d);
        @(posedge core_clk_in);
        addr_out <= a;
        wdata_out <= {16'h0000, d};
        be_out <= 4'h3;
        rd_out <= ~w;
        wr_out <= w;
        @(posedge core_clk_in);
        while (wait_in !== 1'b0) begin
            @(posedge core_clk_in);
        end
        rd_out <= 1'b0;
        wr_out <= 1'b0;
    endtask
endmodule // mgmt_host_model

// *** dv/testbench.sv ***
// self-checking bench for the phy event status and downshift block
// assumes the host model drives the bus and timers are shortened to 20 and 30
`timescale 1ns/1ps
module testbench;
    import phy_event_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic soft_rst_in = 1'b0;
    phy_ind_s ind = '0;
    logic [4:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic wreq;
    logic irq;
    logic adv;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;
    int seed = 32'h387b9061;
    logic [31:0] exp_q[$];
    logic [15:0] en;
    logic [2:0] lim;
    // indication field, status bit it sets, and whether it is a pulse or a toggle
    int fld[11] = '{11, 10, 9, 6, 5, 4, 7, 7, 3, 2, 1};
    int sbit[11] = '{15, 15, 15, 14, 13, 12, 10, 11, 6, 1, 0};
    bit pls[11] = '{1, 1, 1, 0, 0, 1, 0, 0, 0, 0, 1};

    always #2.5 core_clk_in = ~core_clk_in;

    phy_event_status #(.STAB_CYC(20), .LINK_WAIT_CYC(30)) dut_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .soft_rst_in(soft_rst_in), .phy_in(ind),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .irq_out(irq), .adv_100_out(adv)
    );

    mgmt_host_model host_u (
        .core_clk_in(core_clk_in), .wait_in(wreq), .addr_out(addr), .rd_out(rd),
        .wr_out(wr), .wdata_out(wdata), .be_out(be)
    );

    task automatic close_out();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask

    task automatic rdx(input logic [4:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host_u.access(a, 1'b0, 16'h0000);
    endtask

    task automatic wrx(input logic [4:0] a, input logic [15:0] d);
        host_u.access(a, 1'b1, d);
    endtask

    task automatic pulse_bit(input int f);
        @(posedge core_clk_in);
        ind[f] <= 1'b1;
        @(posedge core_clk_in);
        ind[f] <= 1'b0;
    endtask

    // read data stand at the edge that sees waitrequest low
    always @(posedge core_clk_in) begin
        cyc++;
        if (rd === 1'b1 && wreq === 1'b0) begin
            chk(rdata, exp_q.pop_front());
        end
        if (cyc > 20000) begin
            mismatches++;
            close_out();
        end
    end

    initial begin
        tick(16);
        rst_in <= 1'b0;
        rdx(5'h14, 32'h002C);
        rdx(5'h13, 32'h0);
        rdx(5'h12, 32'h0);
        rdx(5'h05, 32'h0);
        wrx(5'h14, 16'hFFFF);
        rdx(5'h14, 32'h06FF);
        for (int i = 0; i < 11; i++) begin
            en = 16'($random(seed)) & 16'hFC63;
            wrx(5'h12, en);
            tick(1);
            ind[fld[i]] <= ~ind[fld[i]];
            if (pls[i]) begin
                tick(1);
                ind[fld[i]] <= 1'b0;
            end
            tick(3);
            chk_bit(irq, en[sbit[i]]);
            rdx(5'h13, 32'h1 << sbit[i]);
            tick(2);
            chk_bit(irq, 1'b0);
            rdx(5'h13, 32'h0);
        end
        // a cause still present at the read keeps its bit
        @(posedge core_clk_in);
        ind.jabber <= 1'b1;
        rdx(5'h13, 32'h1);
        rdx(5'h13, 32'h1);
        ind.jabber <= 1'b0;
        rdx(5'h13, 32'h1);
        rdx(5'h13, 32'h0);
        // negotiation done but no link: flagged once after the wait
        ind.an_done <= 1'b1;
        tick(35);
        rdx(5'h13, 32'h8000);
        rdx(5'h13, 32'h0);
        ind.an_done <= 1'b0;
        wrx(5'h12, 16'h0001);
        pulse_bit(1);
        tick(3);
        chk_bit(irq, 1'b1);
        wrx(5'h12, 16'h0000);
        tick(2);
        chk_bit(irq, 1'b0);
        wrx(5'h18, 16'h0001);
        rdx(5'h13, 32'h0);
        lim = 3'($random(seed));
        wrx(5'h14, {10'h000, 1'b1, lim, 1'b1, 1'b0});
        repeat (int'(lim) + 1) pulse_bit(0);
        tick(4);
        chk_bit(adv, 1'b1);
        pulse_bit(0);
        tick(3);
        chk_bit(adv, 1'b0);
        rdx(5'h13, 32'h0020);
        pulse_bit(1);
        pulse_bit(0);
        soft_rst_in <= 1'b1;
        @(posedge core_clk_in);
        soft_rst_in <= 1'b0;
        tick(2);
        chk_bit(adv, 1'b1);
        rdx(5'h13, 32'h0001);
        wrx(5'h14, 16'h002C);
        repeat (5) pulse_bit(0);
        tick(10);
        chk_bit(adv, 1'b1);
        tick(20);
        chk_bit(adv, 1'b0);
        pulse_bit(1);
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        tick(16);
        rst_in <= 1'b0;
        rdx(5'h13, 32'h0);
        chk_bit(adv, 1'b1);
        rdx(5'h14, 32'h002C);
        close_out();
    end
endmodule // testbench
